/* rtl/pcu_pkg.sv */
// Overview of operation
// - Fetch, decode and execute stages; one clock per instruction, branches longer
// - Four low-active external pins plus serial and host peripheral requests
// - Every interrupt source has its own enable input
// - A higher-priority interrupt may preempt a routine already in service
// - Loops whose body is three or more words repeat with zero overhead; four-deep loop stack for nesting
// - Fifteen-entry program counter stack for calls and interrupt entries
// - Pin variant: system clock is input clock times one to eight
// - Option variant: multiply one to sixteen or divide one to sixteen
// - Halt instruction enters light standby; interrupt or reset resumes
// - Stop instruction enters deep standby; reset or enabled wake pin exits
// - First sixty-four instruction words hold the interrupt vector table
// - Boot loader may write instruction memory through the boot port
// - After reset and boot, fetching starts at address 0x200
package pcu_pkg;
   // ==================================================================
   // Widths and depths
   localparam int ADDR_W = 16;
   localparam int INSTR_W = 32;
   localparam int EXT_IRQS = 4;
   localparam int SRCS = 6;
   localparam int SRC_IDX_W = 3;
   localparam int PC_STACK_DEPTH = 15;
   localparam int PC_SP_W = 4;
   localparam int LOOP_DEPTH = 4;
   localparam int LOOP_SP_W = 3;
   localparam int LOOP_CNT_W = 12;
   localparam int FACTOR_W = 5;

   // ==================================================================
   // Addresses and codes
   localparam logic [ADDR_W-1:0] RESET_ENTRY = 16'h0200;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
   localparam int VEC_SHIFT = 2;
   localparam int VEC_WORDS = 64;
   localparam logic [SRC_IDX_W-1:0] SRC_SIO = 3'h4;
   localparam logic [SRC_IDX_W-1:0] SRC_HIO = 3'h5;
   localparam logic [SRC_IDX_W-1:0] SRC_NONE = 3'h7;
   localparam logic [LOOP_CNT_W-1:0] LOOP_ONE = 12'h001;
   localparam logic [FACTOR_W-1:0] FACTOR_ONE = 5'h01;
   localparam logic [3:0] DIV_ONE = 4'h1;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_JMP = 4'h1,
      OP_CALL = 4'h2,
      OP_RET = 4'h3,
      OP_RETI = 4'h4,
      OP_LOOP = 4'h5,
      OP_HALT = 4'h6,
      OP_STOP = 4'h7
   } pcu_op_t;

   typedef enum logic [1:0] {
      BOOT_NONE = 2'h0,
      BOOT_HOST = 2'h1,
      BOOT_BAD = 2'h2,
      BOOT_SELF = 2'h3
   } pcu_boot_mode_t;

   typedef enum logic [1:0] {
      S_BOOT,
      S_RUN,
      S_HALT,
      S_STOP
   } pcu_state_t;

   typedef struct packed {
      pcu_op_t op;
      logic [LOOP_CNT_W-1:0] count;
      logic [ADDR_W-1:0] target;
   } pcu_instr_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] pc;
      pcu_instr_t instr;
   } pcu_exec_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [INSTR_W-1:0] data;
   } pcu_imem_wr_t;

   typedef struct packed {
      logic divide;
      logic [FACTOR_W-1:0] factor;
   } pcu_clk_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] start;
      logic [ADDR_W-1:0] last;
      logic [LOOP_CNT_W-1:0] count;
   } pcu_loop_t;
endpackage

/* rtl/pcu_core.sv */
`timescale 1ns/100ps
module pcu_core (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [pcu_pkg::EXT_IRQS-1:0] ext_irq_pins_in,
   input wire logic sio_irq_in,
   input wire logic hio_irq_in,
   input wire logic [pcu_pkg::SRCS-1:0] irq_enable_in,
   input wire logic stop_exit_pin_in,
   input wire logic wake_enable_in,
   input wire pcu_pkg::pcu_boot_mode_t boot_mode_in,
   input wire logic boot_done_in,
   input wire pcu_pkg::pcu_imem_wr_t boot_wr_in,
   output pcu_pkg::pcu_imem_wr_t imem_wr_out,
   output logic [pcu_pkg::ADDR_W-1:0] imem_addr_out,
   output logic imem_rd_out,
   input wire logic [pcu_pkg::INSTR_W-1:0] imem_data_in,
   output pcu_pkg::pcu_exec_t exec_out,
   input wire logic clk_pin_variant_in,
   input wire logic [2:0] clk_pll_pins_in,
   input wire logic clk_opt_divide_in,
   input wire logic [3:0] clk_opt_factor_in,
   output pcu_pkg::pcu_clk_cfg_t clk_cfg_out,
   output logic system_clock_output_out,
   output pcu_pkg::pcu_state_t state_out,
   output logic [pcu_pkg::SRCS-1:0] irq_pending_out,
   output logic [pcu_pkg::SRCS-1:0] irq_in_service_out,
   output logic [pcu_pkg::PC_SP_W-1:0] pc_depth_out,
   output logic [pcu_pkg::LOOP_SP_W-1:0] loop_depth_out,
   output logic stack_error_out
);
   import pcu_pkg::*;

   // ==================================================================
   // Helpers
   function automatic logic [SRC_IDX_W-1:0] first_set(
      input logic [SRCS-1:0] v);
      logic [SRC_IDX_W-1:0] idx;
      idx = SRC_NONE;
      for (int i = SRCS - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = SRC_IDX_W'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [SRCS-1:0] below(
      input logic [SRC_IDX_W-1:0] idx);
      logic [SRCS-1:0] m;
      m = '0;
      for (int i = 0; i < SRCS; i++) begin
         m[i] = (SRC_IDX_W'(i) < idx);
      end
      return m;
   endfunction

   function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a);
      return a + ADDR_STEP;
   endfunction

   // ==================================================================
   // State
   pcu_state_t state;
   logic [ADDR_W-1:0] pc;
   logic f_v;
   logic [ADDR_W-1:0] f_pc;
   pcu_exec_t ex;
   logic [EXT_IRQS-1:0] ext_prev;
   logic [SRCS-1:0] pend;
   logic [SRCS-1:0] isr;
   logic [ADDR_W-1:0] pc_stack [PC_STACK_DEPTH];
   logic [PC_SP_W-1:0] pc_sp;
   pcu_loop_t loop_stack [LOOP_DEPTH];
   logic [LOOP_SP_W-1:0] lp_sp;
   logic stack_err;
   pcu_clk_cfg_t clk_cfg;
   logic [3:0] div_cnt;
   logic sys_clk;
   pcu_imem_wr_t imem_wr;

   // ==================================================================
   // Execute stage decode
   wire pcu_op_t e_op = ex.instr.op;
   wire e_jmp = ex.valid && (e_op == OP_JMP);
   wire e_call = ex.valid && (e_op == OP_CALL);
   wire e_reti = ex.valid && (e_op == OP_RETI);
   wire e_ret = ex.valid && ((e_op == OP_RET) || e_reti);
   wire e_halt = ex.valid && (e_op == OP_HALT);
   wire e_stop = ex.valid && (e_op == OP_STOP);
   wire e_loop = ex.valid && (e_op == OP_LOOP);
   wire [ADDR_W-1:0] e_next = step(ex.pc);
   // Standby entry is a redirect to the resume address so fetch is parked
   wire e_redir = e_jmp || e_call || e_ret || e_halt || e_stop;
   wire [PC_SP_W-1:0] pc_top = pc_sp - 4'h1;
   // A return on an empty stack restarts at the reset entry, never at an
   // unknown address; the error flag records the misuse
   wire pc_empty = (pc_sp == '0);
   wire [ADDR_W-1:0] pc_ret = pc_empty ? RESET_ENTRY : pc_stack[pc_top];
   wire [ADDR_W-1:0] e_target = (e_jmp || e_call) ? ex.instr.target :
                                e_ret ? pc_ret : e_next;

   // ==================================================================
   // Interrupt selection
   wire [SRCS-1:0] irq_edge = {hio_irq_in, sio_irq_in,
                               ext_prev & ~ext_irq_pins_in};
   wire [SRCS-1:0] irq_ready = pend & irq_enable_in;
   wire [SRC_IDX_W-1:0] isr_top = first_set(isr);
   // Only sources more urgent than the routine in service may preempt
   wire [SRCS-1:0] irq_allowed = irq_ready & below(isr_top);
   wire [SRC_IDX_W-1:0] acc_src = first_set(irq_allowed);
   wire acc = (state == S_RUN) && !e_redir && (acc_src != SRC_NONE);
   wire [ADDR_W-1:0] acc_vec = ADDR_W'(acc_src) << VEC_SHIFT;
   wire [ADDR_W-1:0] acc_ret = f_v ? f_pc : pc;
   wire [SRCS-1:0] acc_clr = acc ? (SRCS'(1) << acc_src) : '0;
   wire [SRCS-1:0] reti_clr = (e_reti && (isr_top != SRC_NONE)) ?
                              (SRCS'(1) << isr_top) : '0;

   // ==================================================================
   // Loop control
   wire [LOOP_SP_W-1:0] lp_top = lp_sp - 3'h1;
   wire pcu_loop_t lp_cur = loop_stack[lp_top[1:0]];
   // The end check on the fetch address only sees loops whose end lies at
   // least three words past the loop instruction; shorter bodies run once
   wire lp_at_end = (state == S_RUN) && (lp_sp != '0) && !e_redir &&
                    !acc && !e_loop && (pc == lp_cur.last);
   wire lp_again = lp_at_end && (lp_cur.count > LOOP_ONE);
   wire lp_pop = lp_at_end && !lp_again;
   wire lp_full = (lp_sp == LOOP_SP_W'(LOOP_DEPTH));
   wire lp_push = e_loop && !lp_full;

   // ==================================================================
   // Fetch address and pipeline advance
   wire run = (state == S_RUN);
   wire [ADDR_W-1:0] next_pc = e_redir ? e_target :
                               acc ? acc_vec :
                               !run ? pc :
                               lp_again ? lp_cur.start : step(pc);
   wire flush = e_redir || acc;
   wire next_f_v = run && !flush;
   wire next_e_v = f_v && !flush;
   wire pcu_instr_t f_instr = pcu_instr_t'(imem_data_in);

   // PC stack pushes on calls and accepted interrupts, pops on returns
   wire pc_push = e_call || acc;
   wire pc_full = (pc_sp == PC_SP_W'(PC_STACK_DEPTH));
   wire [ADDR_W-1:0] pc_push_val = e_call ? e_next : acc_ret;
   wire pc_err = (pc_push && pc_full) || (e_ret && pc_empty);
   wire lp_err = e_loop && !lp_push;

   // ==================================================================
   // Clock setting
   wire [FACTOR_W-1:0] next_factor = clk_pin_variant_in ?
      (FACTOR_W'(clk_pll_pins_in) + FACTOR_ONE) :
      (FACTOR_W'(clk_opt_factor_in) + FACTOR_ONE);
   wire next_divide = clk_pin_variant_in ? 1'b0 : clk_opt_divide_in;
   wire [3:0] div_last = clk_cfg.factor[3:0] - DIV_ONE;
   // Multiplication is the analog loop's job; here the fastest toggle
   // A smaller ratio cuts the current half period short (>= compare)
   wire div_wrap = !clk_cfg.divide || (div_cnt >= div_last);

   // ==================================================================
   // Control state machine
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state <= S_BOOT;
      end else begin
         unique case (state)
            S_BOOT: begin
               if (boot_mode_in == BOOT_NONE || boot_done_in) begin
                  state <= S_RUN;
               end
            end
            S_RUN: begin
               if (e_halt) begin
                  state <= S_HALT;
               end else if (e_stop) begin
                  state <= S_STOP;
               end
            end
            S_HALT: begin
               if (irq_ready != '0) begin
                  state <= S_RUN;
               end
            end
            S_STOP: begin
               if (wake_enable_in && stop_exit_pin_in) begin
                  state <= S_RUN;
               end
            end
         endcase
      end
   end

   // ==================================================================
   // Pipeline registers
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         pc <= RESET_ENTRY;
         f_v <= 1'b0;
         f_pc <= '0;
         ex <= '0;
      end else begin
         pc <= next_pc;
         f_v <= next_f_v;
         f_pc <= pc;
         ex.valid <= next_e_v;
         ex.pc <= f_pc;
         ex.instr <= f_instr;
      end
   end

   // ==================================================================
   // Interrupt flags; a new request beats the clear of the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         ext_prev <= '1;
         pend <= '0;
         isr <= '0;
      end else begin
         ext_prev <= ext_irq_pins_in;
         pend <= (pend & ~acc_clr) | irq_edge;
         isr <= (isr & ~reti_clr) | acc_clr;
      end
   end

   // ==================================================================
   // PC stack
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         pc_sp <= '0;
      end else if (pc_push && !pc_full) begin
         pc_stack[pc_sp] <= pc_push_val;
         pc_sp <= pc_sp + 4'h1;
      end else if (e_ret && !pc_empty) begin
         pc_sp <= pc_top;
      end
   end

   // ==================================================================
   // Loop stack
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         lp_sp <= '0;
      end else if (lp_push) begin
         loop_stack[lp_sp[1:0]].start <= e_next;
         loop_stack[lp_sp[1:0]].last <= ex.instr.target;
         loop_stack[lp_sp[1:0]].count <= ex.instr.count;
         lp_sp <= lp_sp + 3'h1;
      end else if (lp_again) begin
         loop_stack[lp_top[1:0]].count <= lp_cur.count - LOOP_ONE;
      end else if (lp_pop) begin
         lp_sp <= lp_top;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         stack_err <= 1'b0;
      end else if (pc_err || lp_err) begin
         stack_err <= 1'b1;
      end
   end

   // ==================================================================
   // Boot writes to instruction memory, allowed in any state
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         imem_wr <= '0;
      end else begin
         imem_wr <= boot_wr_in;
      end
   end

   // ==================================================================
   // Clock generator setting and system clock output
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         clk_cfg <= '{divide: 1'b0, factor: FACTOR_ONE};
         div_cnt <= '0;
         sys_clk <= 1'b0;
      end else begin
         clk_cfg.divide <= next_divide;
         clk_cfg.factor <= next_factor;
         div_cnt <= div_wrap ? 4'h0 : div_cnt + 4'h1;
         sys_clk <= div_wrap ? !sys_clk : sys_clk;
      end
   end

   // ==================================================================
   // Outputs
   assign imem_addr_out = pc;
   assign imem_rd_out = run;
   assign imem_wr_out = imem_wr;
   assign exec_out = ex;
   assign clk_cfg_out = clk_cfg;
   assign system_clock_output_out = sys_clk;
   assign state_out = state;
   assign irq_pending_out = pend;
   assign irq_in_service_out = isr;
   assign pc_depth_out = pc_sp;
   assign loop_depth_out = lp_sp;
   assign stack_error_out = stack_err;
endmodule

/* tb/pcu_core_props.sv */
`timescale 1ns/100ps
// ==================================================================
// Port checker for the program control core
module pcu_core_props
   import pcu_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [pcu_pkg::EXT_IRQS-1:0] ext_irq_pins_in,
   input wire logic [pcu_pkg::SRCS-1:0] irq_enable_in,
   input wire logic stop_exit_pin_in,
   input wire logic wake_enable_in,
   input wire pcu_pkg::pcu_imem_wr_t boot_wr_in,
   input wire pcu_pkg::pcu_imem_wr_t imem_wr_out,
   input wire logic [pcu_pkg::ADDR_W-1:0] imem_addr_out,
   input wire pcu_pkg::pcu_exec_t exec_out,
   input wire pcu_pkg::pcu_state_t state_out,
   input wire logic [pcu_pkg::SRCS-1:0] irq_pending_out,
   input wire logic [pcu_pkg::SRCS-1:0] irq_in_service_out,
   input wire logic [pcu_pkg::PC_SP_W-1:0] pc_depth_out,
   input wire logic [pcu_pkg::LOOP_SP_W-1:0] loop_depth_out
);
   logic [SRCS-1:0] prev_svc;
   logic [SRCS-1:0] new_svc;
   logic [SRCS-1:0] low_svc;
   logic redir;
   logic idle_irq;
   // Own copy of the old set, cleared with the core on reset
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         prev_svc <= '0;
      end else begin
         prev_svc <= irq_in_service_out;
      end
   end
   assign new_svc = irq_in_service_out & ~prev_svc;
   assign low_svc = prev_svc & (~prev_svc + 6'h01);
   assign redir = exec_out.valid && exec_out.instr.op inside {OP_JMP,
      OP_CALL, OP_RET, OP_RETI, OP_HALT, OP_STOP};
   assign idle_irq = (irq_pending_out & irq_enable_in) == '0;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);
   // ==================================================================
   // Assertions
   a_boot_copy: assert property (
      boot_wr_in.valid |=> imem_wr_out == $past(boot_wr_in))
      else $error("boot write not passed on");
   a_reset_entry: assert property (
      state_out == S_RUN && $past(state_out) == S_BOOT |->
      imem_addr_out == RESET_ENTRY) else $error("bad first fetch");
   a_redirect_flush: assert property (
      redir |=> !exec_out.valid [*2]) else $error("stale instruction ran");
   a_mask_block: assert property (
      new_svc != '0 |-> (new_svc & ~$past(irq_enable_in)) == '0)
      else $error("disabled source serviced");
   a_nest_order: assert property (
      new_svc != '0 && prev_svc != '0 |-> new_svc < low_svc)
      else $error("preempted by lower priority");
   a_vector_table: assert property (
      new_svc != '0 |-> imem_addr_out < 16'h0040)
      else $error("vector outside table");
   a_pin_request: assert property (
      (($past(ext_irq_pins_in) & ~ext_irq_pins_in) != '0) |=>
      (irq_pending_out[3:0] & ~$past(ext_irq_pins_in)
      & $past(ext_irq_pins_in, 2)) == (~$past(ext_irq_pins_in)
      & $past(ext_irq_pins_in, 2))) else $error("pin edge lost");
   a_halt_stay: assert property (
      state_out == S_HALT && idle_irq |=> state_out == S_HALT)
      else $error("halt left without request");
   a_halt_wake: assert property (
      state_out == S_HALT && !idle_irq |=> state_out == S_RUN)
      else $error("halt not left on request");
   a_stop_stay: assert property (
      state_out == S_STOP && !(wake_enable_in && stop_exit_pin_in) |=>
      state_out == S_STOP) else $error("stop left without wake");
   a_stack_bound: assert property (
      pc_depth_out <= 4'(PC_STACK_DEPTH) && loop_depth_out <= 3'(LOOP_DEPTH))
      else $error("stack depth out of range");
   a_loop_gapless: assert property (
      state_out == S_RUN && loop_depth_out != '0 && exec_out.valid &&
      exec_out.instr.op == OP_NOP && idle_irq |=> exec_out.valid)
      else $error("bubble inside loop");
   c_halt: cover property (state_out == S_HALT);
   c_nested: cover property (new_svc != '0 && prev_svc != '0);
   c_wake: cover property (state_out == S_STOP ##1 state_out == S_RUN);
endmodule

bind pcu_core pcu_core_props u_props (.ref_clk_in, .resetn_in,
   .ext_irq_pins_in, .irq_enable_in, .stop_exit_pin_in, .wake_enable_in,
   .boot_wr_in, .imem_wr_out, .imem_addr_out, .exec_out, .state_out,
   .irq_pending_out, .irq_in_service_out, .pc_depth_out, .loop_depth_out);

/* tb/pcu_imem_model.sv */
`timescale 1ns/100ps
// ==================================================================
// Instruction memory: boot path writes, one-cycle synchronous read
module pcu_imem_model
   import pcu_pkg::*;
(
   input wire logic ref_clk_in,
   input wire pcu_pkg::pcu_imem_wr_t wr_in,
   input wire logic [pcu_pkg::ADDR_W-1:0] addr_in,
   input wire logic rd_in,
   output logic [pcu_pkg::INSTR_W-1:0] data_out
);
   // Only ten address bits decode; empty words read as no-operation
   logic [INSTR_W-1:0] mem [0:1023] = '{default: '0};
   always @(posedge ref_clk_in) begin
      if (wr_in.valid) begin
         mem[wr_in.addr[9:0]] <= wr_in.data;
      end
      // Not reading: show a moving pattern, the last word read and its inverse in turn
      data_out <= rd_in ? mem[addr_in[9:0]] : ~data_out;
   end
endmodule

/* tb/dsp_program_control_unit_tb.sv */
`timescale 1ns/100ps
// ==================================================================
// Bench for the program control core
module dsp_program_control_unit_tb;
   import pcu_pkg::*;
   logic ref_clk_in = 1'b0, resetn_in = 1'b0, track = 1'b0;
   logic sio_irq_in = 1'b0, hio_irq_in = 1'b0, boot_done_in = 1'b0;
   logic stop_exit_pin_in = 1'b0, wake_enable_in = 1'b0;
   logic clk_pin_variant_in = 1'b0, clk_opt_divide_in = 1'b0;
   logic [3:0] ext_irq_pins_in = 4'hf, clk_opt_factor_in = 4'h0;
   logic [2:0] clk_pll_pins_in = 3'h0;
   logic [SRCS-1:0] irq_enable_in = 6'h00;
   pcu_boot_mode_t boot_mode_in = BOOT_HOST;
   pcu_imem_wr_t boot_wr_in = '0;
   pcu_imem_wr_t imem_wr_out;
   logic [ADDR_W-1:0] imem_addr_out;
   logic [INSTR_W-1:0] imem_data_in;
   logic imem_rd_out, system_clock_output_out, stack_error_out;
   pcu_exec_t exec_out;
   pcu_clk_cfg_t clk_cfg_out;
   pcu_state_t state_out;
   logic [SRCS-1:0] irq_pending_out, irq_in_service_out;
   logic [PC_SP_W-1:0] pc_depth_out;
   logic [LOOP_SP_W-1:0] loop_depth_out;
   logic [5:0] ecfg;
   logic sclk;
   int failures = 0, n_checks = 0, cycles = 0, gap = 0;
   logic [ADDR_W-1:0] expq[$];
   logic [15:0] pa [10] = '{16'h0201, 16'h0205, 16'h0206, 16'h0207,
      16'h0208, 16'h0209, 16'h0210, 16'h0212, 16'h0000, 16'h001f};
   logic [31:0] pi [10] = '{32'h5003_0204, 32'h2000_0210, 32'h6000_0000,
      32'h7000_0000, 32'h6000_0000, 32'h6000_0000, 32'h1000_0212,
      32'h3000_0000, 32'h4000_0000, 32'h4000_0000};
   pcu_core uut (.ref_clk_in, .resetn_in, .ext_irq_pins_in, .sio_irq_in,
      .hio_irq_in, .irq_enable_in, .stop_exit_pin_in, .wake_enable_in,
      .boot_mode_in, .boot_done_in, .boot_wr_in, .imem_wr_out,
      .imem_addr_out, .imem_rd_out, .imem_data_in, .exec_out,
      .clk_pin_variant_in, .clk_pll_pins_in, .clk_opt_divide_in,
      .clk_opt_factor_in, .clk_cfg_out, .system_clock_output_out,
      .state_out, .irq_pending_out, .irq_in_service_out, .pc_depth_out,
      .loop_depth_out, .stack_error_out);
   pcu_imem_model mem (.ref_clk_in(ref_clk_in), .wr_in(imem_wr_out),
      .addr_in(imem_addr_out), .rd_in(imem_rd_out), .data_out(imem_data_in));
   // ==================================================================
   // Clock, timeout and helpers
   initial begin
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic check(input string n, input logic [31:0] seen,
         input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s: expected %h seen %h", n, exp, seen);
      end
   endtask
   // Bounded poll: a missed state costs one mismatch, not a hang
   task automatic await(input int k, input logic [31:0] v);
      int i;
      i = 0;
      while ((k == 0 ? 32'(state_out) : 32'(irq_in_service_out)) !== v
            && i < 300) begin
         @(negedge ref_clk_in);
         i++;
      end
      check("awaited", k == 0 ? 32'(state_out) : 32'(irq_in_service_out), v);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge ref_clk_in);
      s = 1'b0;
   endtask
   // Loop body three times, then the call, jump, return and halt
   task automatic note_program();
      expq.delete();
      expq.push_back(16'h0200);
      expq.push_back(16'h0201);
      repeat (3) begin
         for (int a = 2; a < 5; a++) begin
            expq.push_back(16'h0200 + 16'(a));
         end
      end
      expq.push_back(16'h0205);
      expq.push_back(16'h0210);
      expq.push_back(16'h0212);
      expq.push_back(16'h0206);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Executed addresses are matched in order against the notes
   always @(negedge ref_clk_in) begin
      if (track && exec_out.valid === 1'b1) begin
         check("exec pc", exec_out.pc,
            expq.size() > 0 ? expq.pop_front() : 16'hffff);
      end
   end
   // ==================================================================
   // Tests
   initial begin
      void'($urandom(50));
      repeat (5) @(negedge ref_clk_in);
      resetn_in = 1'b1;
      for (int i = 0; i < 10; i++) begin
         boot_wr_in = '{1'b1, pa[i], pi[i]};
         @(negedge ref_clk_in);
      end
      boot_wr_in = '0;
      note_program();
      track = 1'b1;
      pulse(boot_done_in);
      await(0, S_HALT);
      repeat (3) @(negedge ref_clk_in);
      check("exec left", expq.size(), 0);
      $display("test program finished");
      track = 1'b0;
      pulse(sio_irq_in);
      repeat (4) @(negedge ref_clk_in);
      check("masked state", state_out, S_HALT);
      check("pending", irq_pending_out, 6'h10);
      irq_enable_in = 6'h3f;
      await(1, 6'h10);
      check("pc depth", pc_depth_out, 4'h1);
      ext_irq_pins_in = 4'he;
      await(1, 6'h11);
      check("pc depth", pc_depth_out, 4'h2);
      ext_irq_pins_in = 4'hf;
      await(0, S_STOP);
      check("in service", irq_in_service_out, 6'h00);
      $display("test nesting finished");
      expq.push_back(16'h0208);
      for (int a = 20; a < 32; a++) begin
         expq.push_back(16'(a));
      end
      expq.push_back(16'h0209);
      track = 1'b1;
      stop_exit_pin_in = 1'b1;
      repeat (5) @(negedge ref_clk_in);
      check("stop state", state_out, S_STOP);
      wake_enable_in = 1'b1;
      await(0, S_HALT);
      stop_exit_pin_in = 1'b0;
      pulse(hio_irq_in);
      await(0, S_RUN);
      await(0, S_HALT);
      repeat (3) @(negedge ref_clk_in);
      check("exec left", expq.size(), 0);
      $display("test wake finished");
      for (int i = 0; i < 8; i++) begin
         clk_pin_variant_in = i[0];
         {clk_pll_pins_in, clk_opt_divide_in, clk_opt_factor_in} = 8'($urandom);
         ecfg = i[0] ? {1'b0, 5'(clk_pll_pins_in) + 5'h01}
            : {clk_opt_divide_in, 5'(clk_opt_factor_in) + 5'h01};
         repeat (2) @(negedge ref_clk_in);
         check("clock cfg", clk_cfg_out, ecfg);
      end
      // Divide by three: the output must hold for three reference cycles
      clk_pin_variant_in = 1'b0;
      {clk_opt_divide_in, clk_opt_factor_in} = 5'h12;
      repeat (4) @(negedge ref_clk_in);
      sclk = system_clock_output_out;
      while (system_clock_output_out === sclk && gap < 40) begin
         @(negedge ref_clk_in);
         gap++;
      end
      gap = 0;
      sclk = system_clock_output_out;
      while (system_clock_output_out === sclk && gap < 40) begin
         @(negedge ref_clk_in);
         gap++;
      end
      check("clock gap", gap, 32'h3);
      $display("test clock finished");
      check("halt fetch", imem_rd_out, 1'b0);
      resetn_in = 1'b0;
      boot_mode_in = BOOT_NONE;
      repeat (2) @(negedge ref_clk_in);
      check("reset state", state_out, S_BOOT);
      note_program();
      track = 1'b1;
      resetn_in = 1'b1;
      @(negedge ref_clk_in);
      check("boot skipped", state_out, S_RUN);
      check("first fetch", imem_addr_out, RESET_ENTRY);
      check("fetch on", imem_rd_out, 1'b1);
      await(0, S_HALT);
      repeat (3) @(negedge ref_clk_in);
      check("exec left", expq.size(), 0);
      check("stack error", stack_error_out, 1'b0);
      $display("test reset finished");
      tally_and_finish();
   end
endmodule
